// ===== rtl/ep0_irq_pkg.sv
// Purpose: constants for the endpoint-0 interrupt status block
// Assumes: apb with 32-bit data, one aligned word per register
// Notes: status bit positions follow the control-transfer status layout
package ep0_irq_pkg;
   localparam logic [15:0] CTRL_STATUS_OFFSET = 16'hff28;
   localparam logic [15:0] CTRL_CLEAR_OFFSET = 16'hff2c;
   localparam logic [15:0] CTRL_ENABLE_OFFSET = 16'hff30;
   localparam logic [15:0] STALL_STATUS_OFFSET = 16'hff24;
   localparam logic [15:0] STALL_CLEAR_OFFSET = 16'hff34;
   localparam logic [15:0] EP_STATUS_OFFSET = 16'hff38;
   localparam logic [15:0] TX_BUFFER_OFFSET = 16'hff3c;
   localparam logic [15:0] NAK_CTL_OFFSET = 16'hff40;
   localparam logic [15:0] SETUP_BUFFER_OFFSET = 16'hff44;
   localparam int BIT_FW_DECODE = 0;
   localparam int BIT_SETUP_SEEN = 1;
   localparam int BIT_STATUS_PHASE = 2;
   localparam int BIT_XFER_DONE = 3;
   localparam int BIT_RX_DONE = 4;
   localparam int BIT_TX_DONE = 5;
   localparam int BIT_IN_NAK = 6;
   localparam int BIT_STALL = 0;
   localparam int BIT_EP0_STATUS = 0;
   localparam logic [7:0] CTRL_STATUS_RESET = 8'h00;
   localparam logic [7:0] CTRL_ENABLE_RESET = 8'h7f;
   localparam logic [7:0] EP_STATUS_RESET = 8'h00;
   localparam int SETUP_BYTES = 8;
endpackage

// ===== rtl/usb_ep0_interrupt_status.sv
// Purpose: endpoint-0 control-transfer interrupt status and endpoint-stall flag
// Assumes: usb engine events are single-cycle pulses on mclk_i
// Notes: status clear is by writing 0 to a bit of the clear register
//
// Notes on behaviour
// - stall flag sets when any endpoint stalls, raising an interrupt.
// - firmware-requested stall also sets the stall flag.
// - stall flag never auto-clears on standard requests or setup after overrun.
// - ep0 halt bit in endpoint status masked to zero over the listed window.
// - control interrupt line active while any enabled status bit is set.
// - control status register is read-only, eight bits, writes ignored.
// - writing 0 to a clear register bit forces that status bit to 0.
// - transfer-done and status-phase flags clear on the next setup token.
// - ep0 in token answered by nak sets bit 6 with interrupt.
// - host receiving ep0 transmit data, even zero-length, sets bit 5.
// - transmit data goes on the in token after the one setting nak control.
// - transmit-done clears on the first firmware write to the transmit buffer.
// - status stage completion sets bit 3 with interrupt.
// - zero-length data pid 0 packet in status stage also sets bit 3.
// - entry into the status stage sets bit 2 with interrupt.
// - correctly received setup data sets bit 1 with interrupt.
// - bit 0 set while setup buffer awaits decoding, cleared after full read.
module usb_ep0_interrupt_status (
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [15:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic hw_stall_i,
   input wire logic ep0_halt_i,
   input wire logic halt_mask_req_i,
   input wire logic setup_token_i,
   input wire logic setup_data_ok_i,
   input wire logic [63:0] setup_data_i,
   input wire logic fw_request_i,
   input wire logic in_token_i,
   input wire logic tx_ack_i,
   input wire logic rx_done_i,
   input wire logic status_enter_i,
   input wire logic status_done_i,
   input wire logic null_pid0_status_i,
   output logic ep0_tx_send_o,
   output logic [7:0] ep0_tx_data_o,
   output logic usb_irq_line_a_o,
   output logic stall_irq_o
);
   import ep0_irq_pkg::*;

   logic [7:0] ctrl_xfer_irq_status_reg;
   logic [7:0] ctrl_enable_reg;
   logic endpoint_stall_flag_reg;
   logic ep0_mask_reg;
   logic [7:0] ep_status_reg;
   logic ep0_tx_nak_ctl_reg;
   logic nak_armed_reg;
   logic [7:0] ep0_tx_buffer_reg;
   logic [63:0] setup_data_buffer_reg;
   logic [2:0] setup_rd_idx_reg;
   logic [7:0] status_prev_reg;
   logic irq_pulse_reg;
   logic fw_stall_req;

   logic apb_wr;
   logic apb_rd;

   assign pready_o = 1'b1;
   assign apb_wr = psel_i & penable_i & pwrite_i;
   assign apb_rd = psel_i & penable_i & ~pwrite_i;

   function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
      hit = (a == off);
   endfunction

   assign fw_stall_req = apb_wr & hit(paddr_i, EP_STATUS_OFFSET) & pwdata_i[BIT_EP0_STATUS];

   // unmapped addresses answer with an error, data zero
   always_comb begin
      pslverr_o = psel_i & penable_i & ~(hit(paddr_i, CTRL_STATUS_OFFSET)
         | hit(paddr_i, CTRL_CLEAR_OFFSET) | hit(paddr_i, CTRL_ENABLE_OFFSET)
         | hit(paddr_i, STALL_STATUS_OFFSET) | hit(paddr_i, STALL_CLEAR_OFFSET)
         | hit(paddr_i, EP_STATUS_OFFSET) | hit(paddr_i, TX_BUFFER_OFFSET)
         | hit(paddr_i, NAK_CTL_OFFSET) | hit(paddr_i, SETUP_BUFFER_OFFSET));
   end

   // read data registered so the bus sees a flop output
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         prdata_o <= 32'h0000_0000;
      end else if (psel_i & ~penable_i & ~pwrite_i) begin
         unique case (paddr_i)
            CTRL_STATUS_OFFSET: prdata_o <= {24'h00_0000, 1'b0, ctrl_xfer_irq_status_reg[6:0]};
            CTRL_ENABLE_OFFSET: prdata_o <= {24'h00_0000, ctrl_enable_reg};
            STALL_STATUS_OFFSET: prdata_o <= {31'h0000_0000, endpoint_stall_flag_reg};
            EP_STATUS_OFFSET: prdata_o <= {24'h00_0000, ep_status_reg[7:1],
               ep_status_reg[BIT_EP0_STATUS] & ~ep0_mask_reg};
            TX_BUFFER_OFFSET: prdata_o <= {24'h00_0000, ep0_tx_buffer_reg};
            NAK_CTL_OFFSET: prdata_o <= {31'h0000_0000, ep0_tx_nak_ctl_reg};
            SETUP_BUFFER_OFFSET: prdata_o <= {24'h00_0000,
               setup_data_buffer_reg[{setup_rd_idx_reg, 3'b000} +: 8]};
            default: prdata_o <= 32'h0000_0000;
         endcase
      end
   end

   // control status flags: set beats clear in the same cycle
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ctrl_xfer_irq_status_reg <= CTRL_STATUS_RESET;
      end else begin
         logic [7:0] s;
         s = ctrl_xfer_irq_status_reg;
         if (apb_wr & hit(paddr_i, CTRL_CLEAR_OFFSET)) begin
            s = s & pwdata_i[7:0];
         end
         if (setup_token_i) begin
            s[BIT_XFER_DONE] = 1'b0;
            s[BIT_STATUS_PHASE] = 1'b0;
         end
         if (apb_wr & hit(paddr_i, TX_BUFFER_OFFSET)) begin
            s[BIT_TX_DONE] = 1'b0;
         end
         if (apb_rd & hit(paddr_i, SETUP_BUFFER_OFFSET) && setup_rd_idx_reg == 3'(SETUP_BYTES - 1)) begin
            s[BIT_FW_DECODE] = 1'b0;
         end
         if (in_token_i & ~nak_armed_reg) begin
            s[BIT_IN_NAK] = 1'b1;
         end
         if (tx_ack_i) begin
            s[BIT_TX_DONE] = 1'b1;
         end
         if (rx_done_i) begin
            s[BIT_RX_DONE] = 1'b1;
         end
         if (status_done_i | null_pid0_status_i) begin
            s[BIT_XFER_DONE] = 1'b1;
         end
         if (status_enter_i) begin
            s[BIT_STATUS_PHASE] = 1'b1;
         end
         if (setup_data_ok_i) begin
            s[BIT_SETUP_SEEN] = 1'b1;
            if (fw_request_i) begin
               s[BIT_FW_DECODE] = 1'b1;
            end
         end
         // bus writes to the status address never alter it
         s[7] = 1'b0;
         ctrl_xfer_irq_status_reg <= s;
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ctrl_enable_reg <= CTRL_ENABLE_RESET;
      end else if (apb_wr & hit(paddr_i, CTRL_ENABLE_OFFSET)) begin
         ctrl_enable_reg <= pwdata_i[7:0];
      end
   end

   // a newly set enabled bit pulses the line
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         status_prev_reg <= CTRL_STATUS_RESET;
         irq_pulse_reg <= 1'b0;
      end else begin
         status_prev_reg <= ctrl_xfer_irq_status_reg;
         irq_pulse_reg <= |((ctrl_xfer_irq_status_reg & ~status_prev_reg) & ctrl_enable_reg);
      end
   end

   // level while an enabled bit is set, so a change is never missed
   assign usb_irq_line_a_o = |(ctrl_xfer_irq_status_reg & ctrl_enable_reg) | irq_pulse_reg;

   // stall flag: sticky, only a firmware zero clears it
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         endpoint_stall_flag_reg <= 1'b0;
      end else if (hw_stall_i | fw_stall_req) begin
         endpoint_stall_flag_reg <= 1'b1;
      end else if (apb_wr & hit(paddr_i, STALL_CLEAR_OFFSET) & ~pwdata_i[BIT_STALL]) begin
         endpoint_stall_flag_reg <= 1'b0;
      end
   end

   assign stall_irq_o = endpoint_stall_flag_reg;

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ep_status_reg <= EP_STATUS_RESET;
      end else begin
         if (apb_wr & hit(paddr_i, EP_STATUS_OFFSET)) begin
            ep_status_reg <= pwdata_i[7:0];
         end
         if (hw_stall_i) begin
            ep_status_reg[BIT_EP0_STATUS] <= 1'b1;
         end
      end
   end

   // mask window from listed request to any other setup
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ep0_mask_reg <= 1'b0;
      end else if (ep0_halt_i & (halt_mask_req_i | (setup_data_ok_i & fw_request_i))) begin
         ep0_mask_reg <= 1'b1;
      end else if (setup_data_ok_i) begin
         ep0_mask_reg <= 1'b0;
      end
   end

   // send on the in token after the arming one
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ep0_tx_nak_ctl_reg <= 1'b0;
         nak_armed_reg <= 1'b0;
         ep0_tx_send_o <= 1'b0;
         ep0_tx_data_o <= 8'h00;
      end else begin
         ep0_tx_send_o <= 1'b0;
         if (apb_wr & hit(paddr_i, NAK_CTL_OFFSET)) begin
            ep0_tx_nak_ctl_reg <= pwdata_i[0];
         end
         if (~ep0_tx_nak_ctl_reg) begin
            nak_armed_reg <= 1'b0;
         end else if (in_token_i & ~nak_armed_reg) begin
            nak_armed_reg <= 1'b1;
         end else if (in_token_i) begin
            ep0_tx_send_o <= 1'b1;
            ep0_tx_data_o <= ep0_tx_buffer_reg;
            ep0_tx_nak_ctl_reg <= 1'b0;
            nak_armed_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ep0_tx_buffer_reg <= 8'h00;
      end else if (apb_wr & hit(paddr_i, TX_BUFFER_OFFSET)) begin
         ep0_tx_buffer_reg <= pwdata_i[7:0];
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         setup_data_buffer_reg <= 64'h0000_0000_0000_0000;
         setup_rd_idx_reg <= 3'b000;
      end else if (setup_data_ok_i) begin
         setup_data_buffer_reg <= setup_data_i;
         setup_rd_idx_reg <= 3'b000;
      end else if (apb_rd & hit(paddr_i, SETUP_BUFFER_OFFSET)) begin
         setup_rd_idx_reg <= setup_rd_idx_reg + 3'b001;
      end
   end
endmodule // usb_ep0_interrupt_status

// ===== tb/ep0_irq_assertions.sv
// Purpose: temporal checks at the ports of the ep0 interrupt status block
// Assumes: control interrupt enables stay at reset value while usb events fire
// Notes: bound to every instance of the block
module ep0_irq_checker
   import ep0_irq_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [15:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic hw_stall_i,
   input wire logic setup_data_ok_i,
   input wire logic in_token_i,
   input wire logic tx_ack_i,
   input wire logic status_enter_i,
   input wire logic status_done_i,
   input wire logic null_pid0_status_i,
   input wire logic ep0_tx_send_o,
   input wire logic usb_irq_line_a_o,
   input wire logic stall_irq_o
);
   logic stall_clr_w;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);
   assign stall_clr_w = psel_i && penable_i && pwrite_i && paddr_i == STALL_CLEAR_OFFSET
      && !pwdata_i[0];
   sequence s_status_rd;
      psel_i && !penable_i && !pwrite_i && paddr_i == CTRL_STATUS_OFFSET;
   endsequence
   a_stall_set:
      assert property (hw_stall_i |=> stall_irq_o) else $error("stall flag missed");
   a_stall_sticky:
      assert property (stall_irq_o && !stall_clr_w |=> stall_irq_o) else $error("stall lost");
   a_tx_done_irq:
      assert property (tx_ack_i |=> usb_irq_line_a_o) else $error("tx done no irq");
   a_xfer_done_irq:
      assert property (status_done_i |=> usb_irq_line_a_o) else $error("done no irq");
   a_null_pkt_irq:
      assert property (null_pid0_status_i |=> usb_irq_line_a_o) else $error("null no irq");
   a_stage_irq:
      assert property (status_enter_i |=> usb_irq_line_a_o) else $error("stage no irq");
   a_setup_irq:
      assert property (setup_data_ok_i |=> usb_irq_line_a_o) else $error("setup no irq");
   a_msb_zero:
      assert property (s_status_rd |=> prdata_o[7] == 1'b0) else $error("status msb set");
   a_send_cause:
      assert property (ep0_tx_send_o |-> $past(in_token_i)) else $error("send without in");
endmodule // ep0_irq_checker

bind usb_ep0_interrupt_status ep0_irq_checker ep0_irq_checker_i (.*);

// ===== tb/usb_host_model.sv
// Purpose: usb side of the block, reporting bus events as one-cycle pulses
// Assumes: event index order matches the wiring in tb
// Notes: setup bytes are not held once their store strobe has gone
module usb_host_model (
   input wire logic mclk_i,
   output logic [9:0] ev_o,
   output logic [63:0] setup_data_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      ev_o = 10'h000;
      setup_data_o = 64'h0000_0000_0000_0000;
   end
   task automatic fire(input int k, input logic [63:0] d);
      @(posedge mclk_i);
      ev_o <= 10'h001 << k;
      setup_data_o <= d;
      @(posedge mclk_i);
      ev_o <= 10'h000;
      // inverse pattern so a late sample of the bytes is caught
      setup_data_o <= ~d;
   endtask
endmodule // usb_host_model

// ===== tb/tb.sv
// Purpose: self-checking bench for the ep0 interrupt status block
// Assumes: zero-wait apb slave, events modelled by usb_host_model
// Notes: fixed seed keeps random setup and buffer data repeatable
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; \
   $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import ep0_irq_pkg::*;
   logic mclk_i = 0, rstn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
   logic fw_request_i = 0, ep0_halt_i = 0, pready_o, pslverr_o, serr;
   logic ep0_tx_send_o, usb_irq_line_a_o, stall_irq_o;
   logic [15:0] paddr_i = 16'h0000;
   logic [31:0] pwdata_i = 32'h0000_0000, prdata_o, rd, txw;
   logic [7:0] tx_data;
   logic [63:0] sd, setup_data;
   logic [9:0] ev;
   int err_total = 0, checks_done = 0, sends = 0, seed = 32'h5179;
   // tx done, status done, null packet, status stage, rx done
   int evk[5] = '{5, 8, 9, 7, 6};
   int evb[5] = '{5, 3, 3, 2, 4};
   usb_host_model host_i (.mclk_i(mclk_i), .ev_o(ev), .setup_data_o(setup_data));
   usb_ep0_interrupt_status usb_ep0_interrupt_status_i (.mclk_i(mclk_i), .rstn_i(rstn_i),
      .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
      .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .hw_stall_i(ev[0]), .ep0_halt_i(ep0_halt_i), .halt_mask_req_i(ev[1]),
      .setup_token_i(ev[2]), .setup_data_ok_i(ev[3]), .setup_data_i(setup_data),
      .fw_request_i(fw_request_i), .in_token_i(ev[4]), .tx_ack_i(ev[5]), .rx_done_i(ev[6]),
      .status_enter_i(ev[7]), .status_done_i(ev[8]), .null_pid0_status_i(ev[9]),
      .ep0_tx_send_o(ep0_tx_send_o), .ep0_tx_data_o(tx_data),
      .usb_irq_line_a_o(usb_irq_line_a_o),
      .stall_irq_o(stall_irq_o));
   always #2.5 mclk_i = ~mclk_i;
   always @(posedge mclk_i) if (ep0_tx_send_o === 1'b1) sends++;
   function automatic logic [7:0] bm(input int b);
      return 8'h01 << b;
   endfunction
   task finish_test();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge mclk_i);
      penable_i <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 20);
      if (n >= 20) begin
         err_total++;
         finish_test();
      end
      rd = prdata_o;
      serr = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   initial begin
      repeat (3) @(posedge mclk_i);
      rstn_i <= 1'b1;
      apb(0, CTRL_STATUS_OFFSET, 0);
      `CHK("status", CTRL_STATUS_RESET, rd[7:0])
      for (int i = 0; i < 5; i++) begin
         host_i.fire(evk[i], 0);
         #1 `CHK("irq", 1'b1, usb_irq_line_a_o)
         apb(1, CTRL_STATUS_OFFSET, 32'h0000_0000);
         apb(0, CTRL_STATUS_OFFSET, 0);
         `CHK("status", bm(evb[i]), rd[7:0])
         apb(1, CTRL_CLEAR_OFFSET, {24'h00_0000, ~bm(evb[i])});
         apb(0, CTRL_STATUS_OFFSET, 0);
         `CHK("cleared", 8'h00, rd[7:0])
      end
      host_i.fire(7, 0);
      host_i.fire(8, 0);
      host_i.fire(2, 0);
      apb(0, CTRL_STATUS_OFFSET, 0);
      `CHK("setup clr", 8'h00, rd[7:0])
      host_i.fire(5, 0);
      txw = $random(seed);
      apb(1, TX_BUFFER_OFFSET, txw);
      apb(0, CTRL_STATUS_OFFSET, 0);
      `CHK("tx clr", 8'h00, rd[7:0])
      sd = {$random(seed), $random(seed)};
      fw_request_i <= 1'b1;
      host_i.fire(3, sd);
      apb(0, CTRL_STATUS_OFFSET, 0);
      `CHK("setup", bm(1) | bm(0), rd[7:0])
      for (int i = 0; i < SETUP_BYTES; i++) begin
         apb(0, SETUP_BUFFER_OFFSET, 0);
         `CHK("byte", sd[i*8 +: 8], rd[7:0])
      end
      apb(0, CTRL_STATUS_OFFSET, 0);
      `CHK("decode", bm(1), rd[7:0])
      apb(1, CTRL_CLEAR_OFFSET, 0);
      host_i.fire(0, 0);
      host_i.fire(2, 0);
      apb(0, STALL_STATUS_OFFSET, 0);
      `CHK("stall", 1'b1, rd[0])
      apb(1, STALL_CLEAR_OFFSET, 0);
      apb(0, STALL_STATUS_OFFSET, 0);
      `CHK("stall clr", 1'b0, rd[0])
      apb(1, EP_STATUS_OFFSET, 32'h0000_0001);
      apb(0, STALL_STATUS_OFFSET, 0);
      `CHK("fw stall", 1'b1, rd[0])
      ep0_halt_i <= 1'b1;
      host_i.fire(1, 0);
      apb(0, EP_STATUS_OFFSET, 0);
      `CHK("halt mask", 1'b0, rd[0])
      host_i.fire(4, 0);
      apb(0, CTRL_STATUS_OFFSET, 0);
      `CHK("nak", bm(6), rd[7:0])
      apb(1, NAK_CTL_OFFSET, 32'h0000_0001);
      host_i.fire(4, 0);
      host_i.fire(4, 0);
      repeat (2) @(posedge mclk_i);
      `CHK("sends", 1, sends)
      `CHK("tx data", txw[7:0], tx_data)
      apb(1, CTRL_CLEAR_OFFSET, 0);
      host_i.fire(5, 0);
      apb(1, CTRL_ENABLE_OFFSET, 0);
      #1 `CHK("masked", 1'b0, usb_irq_line_a_o)
      apb(1, CTRL_ENABLE_OFFSET, 32'h0000_007f);
      #1 `CHK("unmasked", 1'b1, usb_irq_line_a_o)
      apb(1, CTRL_CLEAR_OFFSET, 0);
      #1 `CHK("irq clr", 1'b0, usb_irq_line_a_o)
      apb(0, 16'hff00, 0);
      `CHK("unmapped", 1'b1, serr)
      finish_test();
   end
endmodule // tb
